// *** acalu_map.vh ***
// Constants of the accumulator ALU core
// What this block does
// - Carry set on addition carry out, else cleared.
// - Destination bit 0 writes accumulator, 1 writes addressed register.
// - Register-file operand addresses span 0x00 to 0x7F, seven bits.
// - Io-control page decodes 0x5..0xF; special page decodes 0x0..0x15.
// - Power-down flag set at power-up and watchdog clear, cleared by halt.
// - Timeout flag set at power-up, watchdog clear or halt; cleared on timeout.
// - Add register with carry: reg+acc+carry, routed, flags Z DC C, one cycle.
// - Add register: acc+reg, routed, flags Z DC C, one cycle.
// - Add immediate with carry: acc+imm+carry into accumulator, flags, one cycle.
// - Add immediate: acc+imm into accumulator, flags Z DC C, one cycle.
// - AND register: acc&reg, routed, only zero flag, one cycle.
// - Bit clear: zero indexed bit of register, flags unchanged, one cycle.
`ifndef ACALU_MAP_VH
`define ACALU_MAP_VH
`define ACALU_OP_NOP        4'h0
`define ACALU_OP_ADD_REG_C  4'h1
`define ACALU_OP_ADD_REG    4'h2
`define ACALU_OP_ADD_IMM_C  4'h3
`define ACALU_OP_ADD_IMM    4'h4
`define ACALU_OP_AND_REG    4'h5
`define ACALU_OP_BIT_CLEAR  4'h6
`define ACALU_OP_WDT_CLEAR  4'h7
`define ACALU_OP_HALT       4'h8
`define ACALU_OP_IO_WRITE   4'h9
`define ACALU_OP_SF_WRITE   4'hA
`define ACALU_REG_ADDR_MAX  7'h7F
`define ACALU_IO_ADDR_MIN   4'h5
`define ACALU_IO_ADDR_MAX   4'hF
`define ACALU_SF_ADDR_MIN   5'h00
`define ACALU_SF_ADDR_MAX   5'h15
`define ACALU_ACC_RESET     8'h00
`define ACALU_FLAG_RESET    1'b0
`define ACALU_PWR_FLAG_RST  1'b1
`endif

// *** acalu_adder.v ***
// Eight-bit adder with carry in, digit carry and carry out
`timescale 1ns/100ps
`default_nettype none
module acalu_adder (
  input  wire [7:0] i_a,
  input  wire [7:0] i_b,
  input  wire       i_cin,
  output wire [7:0] o_sum,
  output wire       o_dc,
  output wire       o_c
);
  wire [4:0] low_sum;
  wire [4:0] high_sum;
  // Low nibble gives digit carry, high nibble the carry
  assign low_sum  = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
  assign high_sum = {1'b0, i_a[7:4]} + {1'b0, i_b[7:4]} + {4'h0, low_sum[4]};
  assign o_sum = {high_sum[3:0], low_sum[3:0]};
  assign o_dc  = low_sum[4];
  assign o_c   = high_sum[4];
endmodule
`default_nettype wire

// *** acalu_page_decode.v ***
// Operand page range decoder
`timescale 1ns/100ps
`default_nettype none
`include "acalu_map.vh"
module acalu_page_decode (
  input  wire [6:0] i_addr,
  output wire       o_reg_ok,
  output wire       o_io_ok,
  output wire       o_sf_ok
);
  // Range checks for each operand page
  assign o_reg_ok = (i_addr <= `ACALU_REG_ADDR_MAX);
  assign o_io_ok  = (i_addr[6:4] == 3'h0) && (i_addr[3:0] >= `ACALU_IO_ADDR_MIN)
                    && (i_addr[3:0] <= `ACALU_IO_ADDR_MAX);
  assign o_sf_ok  = (i_addr[6:5] == 2'h0) && (i_addr[4:0] <= `ACALU_SF_ADDR_MAX);
endmodule
`default_nettype wire

// *** acalu_core.v ***
// Accumulator ALU core: add, add with carry, AND, bit clear and status flags
`timescale 1ns/100ps
`default_nettype none
`include "acalu_map.vh"
module acalu_core (
  input  wire       i_clock,
  input  wire       i_rst_n,
  input  wire       i_exec,
  input  wire [3:0] i_opcode,
  input  wire [6:0] i_addr,
  input  wire       i_dest,
  input  wire [2:0] i_bit_index,
  input  wire [7:0] i_imm,
  input  wire [7:0] i_reg_rdata,
  input  wire       i_wdt_timeout,
  output reg  [7:0] o_accumulator,
  output reg        o_zero_flag,
  output reg        o_digit_carry_flag,
  output reg        o_carry_flag,
  output reg        o_power_down_flag,
  output reg        o_timeout_flag,
  output reg        o_reg_we,
  output reg  [6:0] o_reg_waddr,
  output reg  [7:0] o_reg_wdata,
  output reg        o_io_we,
  output reg        o_sf_we,
  output reg        o_addr_error
);
  reg        wdt_sync_1;
  reg        wdt_sync_2;
  reg        wdt_seen;
  wire       wdt_edge;
  reg  [7:0] add_b;
  reg        add_cin;
  wire [7:0] sum;
  wire       sum_dc;
  wire       sum_c;
  wire       reg_ok;
  wire       io_ok;
  wire       sf_ok;
  reg  [7:0] next_result;
  reg        next_flags_arith;
  reg        next_flags_zero;
  reg        next_to_reg;
  reg        next_to_acc;
  reg  [7:0] bit_mask;
  wire       is_add;
  wire       exec_ok;
  wire       is_wdt_clear;
  wire       is_halt;
  wire       is_page_write;
  reg  [7:0] next_accumulator;
  reg        next_zero;
  reg        next_dc;
  reg        next_carry;
  reg        next_power_down;
  reg        next_timeout;
  reg        next_reg_we;
  reg        next_io_we;
  reg        next_sf_we;
  reg        next_addr_error;
  reg  [6:0] next_reg_waddr;
  reg  [7:0] next_reg_wdata;

  acalu_adder u_adder (
    .i_a   (o_accumulator),
    .i_b   (add_b),
    .i_cin (add_cin),
    .o_sum (sum),
    .o_dc  (sum_dc),
    .o_c   (sum_c)
  );

  acalu_page_decode u_decode (
    .i_addr   (i_addr),
    .o_reg_ok (reg_ok),
    .o_io_ok  (io_ok),
    .o_sf_ok  (sf_ok)
  );

  assign is_add = (i_opcode == `ACALU_OP_ADD_REG_C) || (i_opcode == `ACALU_OP_ADD_REG)
                  || (i_opcode == `ACALU_OP_ADD_IMM_C) || (i_opcode == `ACALU_OP_ADD_IMM);

  // Adder operand and carry in selection
  always @* begin
    add_b   = i_reg_rdata;
    add_cin = 1'b0;
    case (i_opcode)
      `ACALU_OP_ADD_REG_C: begin
        add_b   = i_reg_rdata;
        add_cin = o_carry_flag;
      end
      `ACALU_OP_ADD_REG: begin
        add_b   = i_reg_rdata;
        add_cin = 1'b0;
      end
      `ACALU_OP_ADD_IMM_C: begin
        add_b   = i_imm;
        add_cin = o_carry_flag;
      end
      `ACALU_OP_ADD_IMM: begin
        add_b   = i_imm;
        add_cin = 1'b0;
      end
      default: begin
        add_b   = i_reg_rdata;
        add_cin = 1'b0;
      end
    endcase
  end

  // Result, routing and flag update selection
  always @* begin
    bit_mask         = 8'h01 << i_bit_index;
    next_result      = 8'h00;
    next_flags_arith = 1'b0;
    next_flags_zero  = 1'b0;
    next_to_reg      = 1'b0;
    next_to_acc      = 1'b0;
    case (i_opcode)
      `ACALU_OP_ADD_REG_C, `ACALU_OP_ADD_REG: begin
        next_result      = sum;
        next_flags_arith = 1'b1;
        next_to_reg      = i_dest;
        next_to_acc      = ~i_dest;
      end
      `ACALU_OP_ADD_IMM_C, `ACALU_OP_ADD_IMM: begin
        next_result      = sum;
        next_flags_arith = 1'b1;
        next_to_acc      = 1'b1;
      end
      `ACALU_OP_AND_REG: begin
        next_result     = o_accumulator & i_reg_rdata;
        next_flags_zero = 1'b1;
        next_to_reg     = i_dest;
        next_to_acc     = ~i_dest;
      end
      `ACALU_OP_BIT_CLEAR: begin
        next_result = i_reg_rdata & ~bit_mask;
        next_to_reg = 1'b1;
      end
      default: begin
        next_result = 8'h00;
      end
    endcase
  end

  // Two-stage synchroniser for the timeout pin from the watchdog domain
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wdt_sync_1 <= 1'b0;
      wdt_sync_2 <= 1'b0;
    end else begin
      wdt_sync_1 <= i_wdt_timeout;
      wdt_sync_2 <= wdt_sync_1;
    end
  end

  // Delayed copy for rising edge detect; resets to the pin's idle low
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wdt_seen <= 1'b0;
    end else begin
      wdt_seen <= wdt_sync_2;
    end
  end
  assign wdt_edge = wdt_sync_2 & ~wdt_seen;

  // Decoded execute qualifiers
  assign exec_ok       = i_exec & reg_ok;
  assign is_wdt_clear  = i_exec & (i_opcode == `ACALU_OP_WDT_CLEAR);
  assign is_halt       = i_exec & (i_opcode == `ACALU_OP_HALT);
  assign is_page_write = (i_opcode == `ACALU_OP_IO_WRITE) || (i_opcode == `ACALU_OP_SF_WRITE);

  // Next accumulator, written only when the destination is the accumulator
  always @* begin
    next_accumulator = o_accumulator;
    if (exec_ok && next_to_acc) begin
      next_accumulator = next_result;
    end
  end

  // Next zero flag, written by additions and AND
  always @* begin
    next_zero = o_zero_flag;
    if (exec_ok && (next_flags_arith || next_flags_zero)) begin
      next_zero = (next_result == 8'h00);
    end
  end

  // Next digit carry and carry, written by additions only
  always @* begin
    next_dc    = o_digit_carry_flag;
    next_carry = o_carry_flag;
    if (exec_ok && is_add) begin
      next_dc    = sum_dc;
      next_carry = sum_c;
    end
  end

  // Accumulator register
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_accumulator <= `ACALU_ACC_RESET;
    end else begin
      o_accumulator <= next_accumulator;
    end
  end

  // Arithmetic flag registers
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_zero_flag        <= `ACALU_FLAG_RESET;
      o_digit_carry_flag <= `ACALU_FLAG_RESET;
      o_carry_flag       <= `ACALU_FLAG_RESET;
    end else begin
      o_zero_flag        <= next_zero;
      o_digit_carry_flag <= next_dc;
      o_carry_flag       <= next_carry;
    end
  end

  // Next power-down flag
  always @* begin
    next_power_down = o_power_down_flag;
    if (is_wdt_clear) begin
      next_power_down = 1'b1;
    end else if (is_halt) begin
      next_power_down = 1'b0;
    end
  end

  // Next timeout flag; the hardware timeout beats a same-cycle set
  always @* begin
    next_timeout = o_timeout_flag;
    if (wdt_edge) begin
      next_timeout = 1'b0;
    end else if (is_wdt_clear || is_halt) begin
      next_timeout = 1'b1;
    end
  end

  // Power-down flag register, set at power-up
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_power_down_flag <= `ACALU_PWR_FLAG_RST;
    end else begin
      o_power_down_flag <= next_power_down;
    end
  end

  // Timeout flag register, set at power-up
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_timeout_flag <= `ACALU_PWR_FLAG_RST;
    end else begin
      o_timeout_flag <= next_timeout;
    end
  end

  // Next write strobes, each a single-cycle pulse
  always @* begin
    next_reg_we     = exec_ok && next_to_reg;
    next_io_we      = i_exec && (i_opcode == `ACALU_OP_IO_WRITE) && io_ok;
    next_sf_we      = i_exec && (i_opcode == `ACALU_OP_SF_WRITE) && sf_ok;
    next_addr_error = i_exec && (((i_opcode == `ACALU_OP_IO_WRITE) && !io_ok)
                      || ((i_opcode == `ACALU_OP_SF_WRITE) && !sf_ok));
  end

  // Next write address and data, held until the next instruction
  always @* begin
    next_reg_waddr = o_reg_waddr;
    next_reg_wdata = o_reg_wdata;
    if (i_exec) begin
      next_reg_waddr = i_addr;
      if (is_page_write) begin
        next_reg_wdata = o_accumulator;
      end else begin
        next_reg_wdata = next_result;
      end
    end
  end

  // Write strobe registers, one cycle after the request
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_we     <= 1'b0;
      o_io_we      <= 1'b0;
      o_sf_we      <= 1'b0;
      o_addr_error <= 1'b0;
    end else begin
      o_reg_we     <= next_reg_we;
      o_io_we      <= next_io_we;
      o_sf_we      <= next_sf_we;
      o_addr_error <= next_addr_error;
    end
  end

  // Write address and data registers
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_waddr <= 7'h00;
      o_reg_wdata <= 8'h00;
    end else begin
      o_reg_waddr <= next_reg_waddr;
      o_reg_wdata <= next_reg_wdata;
    end
  end
endmodule
`default_nettype wire

// *** acalu_core_sva.sv ***
// Assertion checker for the accumulator ALU core
`timescale 1ns/100ps
`default_nettype none
module acalu_core_chk (
  input wire       i_clock,
  input wire       i_rst_n,
  input wire       i_exec,
  input wire [3:0] i_opcode,
  input wire       i_dest,
  input wire [7:0] i_imm,
  input wire [7:0] i_reg_rdata,
  input wire [7:0] o_accumulator,
  input wire       o_zero_flag,
  input wire       o_digit_carry_flag,
  input wire       o_carry_flag,
  input wire       o_power_down_flag,
  input wire       o_reg_we,
  input wire [7:0] o_reg_wdata
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Issued opcode and reference results
  wire [3:0] op = i_exec ? i_opcode : 4'h0;
  wire [7:0] acc = o_accumulator;
  wire [7:0] and_v = acc & i_reg_rdata;
  wire [7:0] add_v = acc + i_reg_rdata;
  wire       dc_v = ({1'b0, acc[3:0]} + {1'b0, i_imm[3:0]}) > 5'h0F;
  chk_add_imm_sum: assert property (op == 4'h4 |=> {o_carry_flag, acc} == $past(acc) + $past(i_imm))
    else $error("add immediate result wrong");
  chk_adc_imm_sum: assert property (op == 4'h3 |=> {o_carry_flag, acc} == $past(acc) + $past(i_imm)
    + $past(o_carry_flag)) else $error("add immediate with carry wrong");
  chk_digit_carry: assert property (op == 4'h4 |=> o_digit_carry_flag == $past(dc_v))
    else $error("digit carry wrong");
  chk_zero_flag: assert property (op == 4'h2 && !i_dest |=> o_zero_flag == (acc == 8'h00))
    else $error("zero flag wrong");
  chk_and_result: assert property (op == 4'h5 && !i_dest |=> acc == $past(and_v) && $stable(o_carry_flag))
    else $error("and result or carry wrong");
  chk_reg_dest: assert property (op == 4'h2 && i_dest |=> o_reg_we
    && o_reg_wdata == $past(add_v) && $stable(acc)) else $error("register destination wrong");
  chk_bclr_flags: assert property (op == 4'h6 |=> $stable({o_zero_flag, o_digit_carry_flag, o_carry_flag}))
    else $error("bit clear changed flags");
  chk_idle_no_write: assert property (op == 4'h0 |=> !o_reg_we)
    else $error("write without instruction");
  chk_halt_pd: assert property (op == 4'h8 |=> !o_power_down_flag)
    else $error("halt kept power down flag");
  chk_wdtclr_pd: assert property (op == 4'h7 |=> o_power_down_flag)
    else $error("watchdog clear left power down flag low");
endmodule
bind acalu_core acalu_core_chk acalu_core_chk_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_exec(i_exec),
  .i_opcode(i_opcode), .i_dest(i_dest), .i_imm(i_imm), .i_reg_rdata(i_reg_rdata), .o_accumulator(o_accumulator),
  .o_zero_flag(o_zero_flag), .o_digit_carry_flag(o_digit_carry_flag), .o_carry_flag(o_carry_flag),
  .o_power_down_flag(o_power_down_flag), .o_reg_we(o_reg_we), .o_reg_wdata(o_reg_wdata));
`default_nettype wire

// *** acalu_tb.sv ***
// Self-checking testbench for the accumulator ALU core
`timescale 1ns/100ps
`default_nettype none
`include "acalu_map.vh"
module tb;
  reg        i_clock = 1'b0;
  reg        i_rst_n = 1'b0;
  reg        i_exec = 1'b0;
  reg  [3:0] i_opcode = 4'h0;
  reg  [6:0] i_addr = 7'h00;
  reg        i_dest = 1'b0;
  reg  [2:0] i_bit_index = 3'h0;
  reg  [7:0] i_imm = 8'h00;
  reg  [7:0] i_reg_rdata = 8'h00;
  reg        i_wdt_timeout = 1'b0;
  wire [7:0] o_accumulator, o_reg_wdata;
  wire [6:0] o_reg_waddr;
  wire       o_zero_flag, o_digit_carry_flag, o_carry_flag, o_power_down_flag, o_timeout_flag;
  wire       o_reg_we, o_io_we, o_sf_we, o_addr_error;
  integer    err_total = 0;
  integer    checked = 0;
  integer    n;
  // Flags: pd, timeout, carry, digit carry, zero; strobes: reg, io, special, error
  wire [7:0] st = {3'h0, o_power_down_flag, o_timeout_flag, o_carry_flag, o_digit_carry_flag, o_zero_flag};
  wire [7:0] wr = {4'h0, o_reg_we, o_io_we, o_sf_we, o_addr_error};
  acalu_core acalu_core_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_exec(i_exec), .i_opcode(i_opcode),
    .i_addr(i_addr), .i_dest(i_dest), .i_bit_index(i_bit_index), .i_imm(i_imm), .i_reg_rdata(i_reg_rdata),
    .i_wdt_timeout(i_wdt_timeout), .o_accumulator(o_accumulator), .o_zero_flag(o_zero_flag),
    .o_digit_carry_flag(o_digit_carry_flag), .o_carry_flag(o_carry_flag), .o_power_down_flag(o_power_down_flag),
    .o_timeout_flag(o_timeout_flag), .o_reg_we(o_reg_we), .o_reg_waddr(o_reg_waddr), .o_reg_wdata(o_reg_wdata),
    .o_io_we(o_io_we), .o_sf_we(o_sf_we), .o_addr_error(o_addr_error));
  // 100 ns clock
  initial forever #50 i_clock = ~i_clock;
  // Value compare
  task cmp(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One instruction; v is immediate and register content
  task op(input [3:0] o, input [6:0] a, input d, input [2:0] b, input [7:0] v);
    begin
      @(negedge i_clock);
      i_exec = 1'b1;
      i_opcode = o;
      i_addr = a;
      i_dest = d;
      i_bit_index = b;
      i_imm = v;
      i_reg_rdata = v;
      @(negedge i_clock);
      i_exec = 1'b0;
    end
  endtask
  task give_verdict;
    begin
      if (err_total == 0 && checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    repeat (5) @(negedge i_clock);
    i_rst_n = 1'b1;
    cmp(st, 8'h18);
    op(`ACALU_OP_ADD_IMM, 7'h00, 1'b0, 3'h0, 8'hF0);
    op(`ACALU_OP_ADD_IMM, 7'h00, 1'b0, 3'h0, 8'h22);
    cmp(o_accumulator, 8'h12);
    cmp(st, 8'h1C);
    op(`ACALU_OP_ADD_REG_C, 7'h7F, 1'b1, 3'h0, 8'h34);
    cmp(o_reg_wdata, 8'h47);
    cmp({o_reg_waddr, o_reg_we}, 8'hFF);
    cmp(o_accumulator, 8'h12);
    cmp(st, 8'h18);
    op(`ACALU_OP_ADD_REG, 7'h01, 1'b0, 3'h0, 8'h34);
    cmp(o_accumulator, 8'h46);
    cmp(wr, 8'h00);
    op(`ACALU_OP_ADD_IMM, 7'h00, 1'b0, 3'h0, 8'hBA);
    cmp(st, 8'h1F);
    op(`ACALU_OP_ADD_IMM_C, 7'h00, 1'b0, 3'h0, 8'h0F);
    cmp(o_accumulator, 8'h10);
    cmp(st, 8'h1A);
    op(`ACALU_OP_AND_REG, 7'h02, 1'b0, 3'h0, 8'hEF);
    cmp(st, 8'h1B);
    op(`ACALU_OP_BIT_CLEAR, 7'h03, 1'b1, 3'h3, 8'h5A);
    cmp(o_reg_wdata, 8'h52);
    op(`ACALU_OP_BIT_CLEAR, 7'h7F, 1'b1, 3'h7, 8'hFF);
    cmp(o_reg_wdata, 8'h7F);
    cmp(st, 8'h1B);
    op(`ACALU_OP_IO_WRITE, 7'h05, 1'b0, 3'h0, 8'h00);
    cmp(wr, 8'h04);
    op(`ACALU_OP_IO_WRITE, 7'h04, 1'b0, 3'h0, 8'h00);
    cmp(wr, 8'h01);
    op(`ACALU_OP_SF_WRITE, 7'h15, 1'b0, 3'h0, 8'h00);
    cmp(wr, 8'h02);
    op(`ACALU_OP_SF_WRITE, 7'h16, 1'b0, 3'h0, 8'h00);
    cmp(wr, 8'h01);
    i_wdt_timeout = 1'b1;
    n = 0;
    while (o_timeout_flag !== 1'b0 && n < 8) begin
      @(negedge i_clock);
      n = n + 1;
    end
    cmp(st, 8'h13);
    if (n == 8) begin
      err_total = err_total + 1;
      give_verdict;
    end
    i_wdt_timeout = 1'b0;
    op(`ACALU_OP_HALT, 7'h00, 1'b0, 3'h0, 8'h00);
    cmp(st, 8'h0B);
    op(`ACALU_OP_WDT_CLEAR, 7'h00, 1'b0, 3'h0, 8'h00);
    cmp(st, 8'h1B);
    op(`ACALU_OP_NOP, 7'h00, 1'b0, 3'h0, 8'h00);
    cmp(wr, 8'h00);
    give_verdict;
  end
endmodule
`default_nettype wire
